// ===== fscd_pkg.sv
package fscd_pkg;

  // register map on the apb side
  localparam int         FSCD_APB_AW    = 8;
  localparam logic [7:0] FSCD_RATIO_OFS = 8'h00;
  localparam logic [7:0] FSCD_CFG_OFS   = 8'h04;
  localparam logic [7:0] FSCD_OPT_OFS   = 8'h08;
  localparam logic [7:0] FSCD_PROT_OFS  = 8'h0c;
  localparam logic [7:0] FSCD_STAT_OFS  = 8'h10;

  // field positions
  localparam int FSCD_RATIO_LD_BIT  = 7;
  localparam int FSCD_RATIO_PS_BIT  = 6;
  localparam int FSCD_RATIO_DIV_HI  = 5;
  localparam int FSCD_OPT_BACKDOOR_UNLOCK_PERMIT_BIT = 7;
  localparam int FSCD_OPT_SEC_HI    = 1;
  localparam int FSCD_OPT_SEC_LO    = 0;
  localparam int FSCD_CFG_KEYSEL    = 5;
  localparam int FSCD_STAT_ERR_BIT  = 0;

  // codes and addresses
  localparam logic [1:0]  FSCD_SEC_OPEN   = 2'h2;
  localparam logic [15:0] FSCD_KEY_BASE   = 16'hffb0;
  localparam logic [15:0] FSCD_VEC_BLOCK  = 16'hfe00;
  localparam logic [3:0]  FSCD_KEY_BYTES  = 4'h8;
  localparam logic [2:0]  FSCD_PRESC_LAST = 3'h7;

  // values after reset
  localparam logic [7:0] FSCD_OPT_RST   = 8'h03;
  localparam logic [7:0] FSCD_PROT_RST  = 8'hff;
  localparam logic [7:0] FSCD_RATIO_RST = 8'h00;

  typedef enum logic [0:0] {
    FSCD_LOAD = 1'b0,
    FSCD_RUN  = 1'b1
  } fscd_phase_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        src_secure;
    logic        bdm;
    logic        tgt_secure;
    logic        tgt_flash;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } fscd_mreq_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } fscd_mfwd_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } fscd_mresp_t;

  typedef struct packed {
    fscd_phase_t phase;
    logic [7:0]  opt;
    logic [7:0]  prot;
    logic [7:0]  ratio;
    logic        key_sel;
    logic        acc_err;
    logic [3:0]  key_idx;
    logic        key_ok;
    logic [2:0]  pcnt;
    logic [5:0]  dcnt;
    logic        fclk_tick;
    logic [1:0]  blk_pipe;
    fscd_mfwd_t  fwd;
    fscd_mresp_t resp;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        dbg_en;
    logic        secure;
  } fscd_state_t;

  localparam fscd_state_t FSCD_STATE_RST = '{
    phase:  FSCD_LOAD,
    opt:    FSCD_OPT_RST,
    prot:   FSCD_PROT_RST,
    ratio:  FSCD_RATIO_RST,
    secure: 1'b1,
    default: '0
  };

endpackage

// ===== fscd_top.sv
`timescale 1ns/1ps
// Function
// RULE1 - unsecured code or debug port cannot touch flash/ram while secure; reads give zero
// RULE2 - code from secure memory has normal access; registers and debug stay reachable
// RULE3 - security field value 1:0 is unsecured, the other three are secure
// RULE4 - every reset copies the stored option byte into the working option register
// RULE5 - on-chip debug module cannot be enabled while secure
// RULE6 - with unlock permit at 0 there is no backdoor unlock
// RULE7 - with key entry selected, key location writes are compare values, not commands
// RULE8 - software writes key bytes in ascending order, never on adjacent bus cycles
// RULE9 - ending key entry with a full matching key sets security field to 1:0
// RULE10 - key writes count only from code running in secure memory
// RULE11 - key and option locations live inside the vector block
// RULE12 - working protection register is written only by debug commands
// RULE13 - a passing blank check disengages security until reset
// RULE14 - ratio bits 6:0 are write-once after reset, bit 7 read-only
// RULE15 - ratio-loaded flag clears at reset, sets on first ratio write; gates program/erase
// RULE16 - divider input is bus clock, or bus clock over 8 when prescale bit is set
// RULE17 - divider divides its input by ratio field plus one
// RULE18 - each timing pulse is one internal flash clock period
// RULE19 - software keeps the internal flash clock between 150 and 200 kHz
// RULE20 - flash write before the ratio is loaded sets access error and is dropped
// RULE21 - a mismatching key leaves the security state unchanged
module fscd_top
#(
  parameter logic [15:0] KEY_BASE_ADDR = fscd_pkg::FSCD_KEY_BASE
)
(
  input  wire logic                  core_clk_i,
  input  wire logic                  arst_n_i,
  input  wire logic                  ce_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [7:0]            paddr_i,
  input  wire logic [31:0]           pwdata_i,
  input  wire logic                  bdm_src_i,
  output logic [31:0]                prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  input  wire logic [7:0]            stored_option_byte_i,
  input  wire logic [7:0]            stored_protection_byte_i,
  input  wire logic [63:0]           stored_unlock_code_i,
  input  wire fscd_pkg::fscd_mreq_t  mem_req_i,
  output fscd_pkg::fscd_mfwd_t       mem_fwd_o,
  input  wire logic                  mem_rvalid_i,
  input  wire logic [7:0]            mem_rdata_i,
  output fscd_pkg::fscd_mresp_t      mem_resp_o,
  input  wire logic                  blank_ok_i,
  input  wire logic                  dbg_en_req_i,
  output logic                       dbg_en_o,
  output logic                       secure_o,
  output logic [7:0]                 working_option_reg_o,
  output logic [7:0]                 working_protection_reg_o,
  output logic                       pe_enable_o,
  output logic                       access_error_flag_o,
  output logic                       fclk_tick_o
);
  import fscd_pkg::*;

  fscd_state_t s;
  fscd_state_t n;
  logic        sec_now;
  logic        permit;
  logic        loaded;
  logic        apb_setup;
  logic        apb_wr;
  logic [7:0]  reg_sel;
  logic        key_hit;
  logic        key_src_ok;
  logic        key_in_order;
  logic        blocked;
  logic        early_wr;
  logic [7:0]  key_byte;
  logic        key_close;
  logic        div_in_tick;
  logic        key_match;

  // key and option storage must share the protected vector block
  if (KEY_BASE_ADDR < FSCD_VEC_BLOCK || KEY_BASE_ADDR[2:0] != 3'h0) // RULE11
  begin : g_bad_key
    $error("key locations must be eight-aligned inside the vector block");
  end

  // decode of current state and requests
  assign sec_now = s.opt[FSCD_OPT_SEC_HI:FSCD_OPT_SEC_LO] != FSCD_SEC_OPEN; // RULE3
  assign permit = s.opt[FSCD_OPT_BACKDOOR_UNLOCK_PERMIT_BIT];
  assign loaded = s.ratio[FSCD_RATIO_LD_BIT];
  assign apb_setup = psel_i && !penable_i;
  assign apb_wr = psel_i && penable_i && s.pready && pwrite_i;
  assign reg_sel = paddr_i[FSCD_APB_AW-1:0];
  assign key_hit = mem_req_i.valid && mem_req_i.write && s.key_sel
                   && (mem_req_i.addr[15:3] == KEY_BASE_ADDR[15:3]); // RULE7
  // debug-sourced or unpermitted key writes poison the attempt
  assign key_src_ok = mem_req_i.src_secure && !mem_req_i.bdm && permit; // RULE10 RULE6
  assign key_in_order = (s.key_idx < FSCD_KEY_BYTES) && (mem_req_i.addr[2:0] == s.key_idx[2:0]);
  assign key_byte = stored_unlock_code_i[{s.key_idx[2:0], 3'h0} +: 8];
  assign blocked = mem_req_i.valid && sec_now && mem_req_i.tgt_secure
                   && (!mem_req_i.src_secure || mem_req_i.bdm); // RULE1 RULE2
  assign early_wr = mem_req_i.valid && mem_req_i.write && mem_req_i.tgt_flash && !loaded; // RULE20
  assign key_close = apb_wr && reg_sel == FSCD_CFG_OFS && !pwdata_i[FSCD_CFG_KEYSEL] && s.key_sel;
  assign key_match = s.key_idx == FSCD_KEY_BYTES && s.key_ok && permit;
  assign div_in_tick = !s.ratio[FSCD_RATIO_PS_BIT] || (s.pcnt == FSCD_PRESC_LAST); // RULE16

  // next-state logic for the whole block
  always_comb
  begin
    n = s;
    n.fclk_tick = 1'b0;
    n.fwd.valid = 1'b0;
    n.pready = apb_setup;
    n.dbg_en = dbg_en_req_i && !sec_now; // RULE5
    n.secure = sec_now;
    // blocked reads answer in the slot a real one-cycle memory would use
    n.blk_pipe = {s.blk_pipe[0], blocked && !mem_req_i.write && !key_hit};
    n.resp.valid = mem_rvalid_i || s.blk_pipe[1];
    n.resp.data = s.blk_pipe[1] ? 8'h00 : mem_rdata_i; // RULE1
    case (s.phase)
      FSCD_LOAD:
      begin
        n.opt = stored_option_byte_i; // RULE4
        n.prot = stored_protection_byte_i;
        n.phase = FSCD_RUN;
      end
      FSCD_RUN:
      begin
        // register writes come first so hardware sets below win over clears
        if (apb_wr)
        begin
          case (reg_sel)
            FSCD_RATIO_OFS:
              if (!loaded)
                n.ratio = {1'b1, pwdata_i[6:0]}; // RULE14 RULE15
            FSCD_CFG_OFS:
            begin
              n.key_sel = pwdata_i[FSCD_CFG_KEYSEL];
              if (pwdata_i[FSCD_CFG_KEYSEL] && !s.key_sel)
              begin
                n.key_idx = 4'h0;
                n.key_ok = 1'b1;
              end
            end
            FSCD_PROT_OFS:
              if (bdm_src_i)
                n.prot = pwdata_i[7:0]; // RULE12
            FSCD_STAT_OFS:
              if (pwdata_i[FSCD_STAT_ERR_BIT])
                n.acc_err = 1'b0;
            default: ;
          endcase
        end
        // a mismatch simply falls through and keeps the field
        if (key_close && key_match)
          n.opt[FSCD_OPT_SEC_HI:FSCD_OPT_SEC_LO] = FSCD_SEC_OPEN; // RULE9 RULE21
        if (blank_ok_i)
          n.opt[FSCD_OPT_SEC_HI:FSCD_OPT_SEC_LO] = FSCD_SEC_OPEN; // RULE13
        // memory access gate
        if (key_hit)
        begin
          if (key_src_ok && key_in_order)
          begin
            n.key_ok = s.key_ok && (mem_req_i.wdata == key_byte); // RULE7
            n.key_idx = s.key_idx + 4'h1;
          end
          else
            n.key_ok = 1'b0; // RULE10
        end
        else if (blocked)
          n.fwd.valid = 1'b0; // RULE1
        else if (early_wr)
          n.acc_err = 1'b1; // RULE20
        else if (mem_req_i.valid)
        begin
          n.fwd.valid = 1'b1; // RULE2
          n.fwd.write = mem_req_i.write;
          n.fwd.addr = mem_req_i.addr;
          n.fwd.wdata = mem_req_i.wdata;
        end
        // flash clock divider, idle until the ratio is loaded
        if (loaded)
        begin
          n.pcnt = s.pcnt + 3'h1;
          if (div_in_tick)
          begin
            if (s.dcnt == s.ratio[FSCD_RATIO_DIV_HI:0]) // RULE17
            begin
              n.dcnt = 6'h00;
              n.fclk_tick = 1'b1; // RULE18
            end
            else
              n.dcnt = s.dcnt + 6'h01;
          end
        end
      end
      default: n.phase = FSCD_LOAD;
    endcase
    // read data is captured in the setup cycle
    if (apb_setup)
    begin
      n.pslverr = 1'b0;
      case (reg_sel)
        FSCD_RATIO_OFS: n.prdata = {24'h000000, s.ratio};
        FSCD_CFG_OFS:   n.prdata = {26'h0000000, s.key_sel, 5'h00};
        FSCD_OPT_OFS:   n.prdata = {24'h000000, s.opt};
        FSCD_PROT_OFS:  n.prdata = {24'h000000, s.prot};
        FSCD_STAT_OFS:  n.prdata = {29'h00000000, loaded, sec_now, s.acc_err};
        default:
        begin
          n.prdata = 32'h00000000;
          n.pslverr = 1'b1;
        end
      endcase
    end
  end

  // single state register; clock enable freezes everything
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      s <= FSCD_STATE_RST;
    else if (ce_i)
      s <= n;
  end

  // outputs straight from the state register
  assign prdata_o = s.prdata;
  assign pready_o = s.pready;
  assign pslverr_o = s.pslverr;
  assign mem_fwd_o = s.fwd;
  assign mem_resp_o = s.resp;
  assign dbg_en_o = s.dbg_en;
  assign secure_o = s.secure;
  assign working_option_reg_o = s.opt;
  assign working_protection_reg_o = s.prot;
  assign pe_enable_o = s.ratio[FSCD_RATIO_LD_BIT]; // RULE15
  assign access_error_flag_o = s.acc_err;
  assign fclk_tick_o = s.fclk_tick;

  // checks on the block's own behaviour
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence key_close_ok_s;
    ce_i && s.phase == FSCD_RUN && key_close && key_match;
  endsequence

  sequence blank_pass_s;
    ce_i && s.phase == FSCD_RUN && blank_ok_i;
  endsequence

  blocked_write_drop_a: assert property ( // RULE1
    ce_i && s.phase == FSCD_RUN && blocked && mem_req_i.write && !key_hit |=> !mem_fwd_o.valid)
    else $error("blocked write was forwarded");

  blocked_read_zero_a: assert property ( // RULE1
    ce_i && s.phase == FSCD_RUN && blocked && !mem_req_i.write && !key_hit
    ##1 ce_i ##1 ce_i |=> mem_resp_o.valid && mem_resp_o.data == 8'h00)
    else $error("blocked read did not return zero");

  secure_fetch_pass_a: assert property ( // RULE2
    ce_i && s.phase == FSCD_RUN && mem_req_i.valid && mem_req_i.src_secure && !mem_req_i.bdm
    && !key_hit && !early_wr |=> mem_fwd_o.valid && mem_fwd_o.addr == $past(mem_req_i.addr))
    else $error("secure access was not forwarded");

  erased_code_secure_a: assert property ( // RULE3
    ce_i && s.opt[1:0] == 2'h3 |=> secure_o)
    else $error("erased security field did not read secure");

  option_load_a: assert property ( // RULE4
    ce_i && s.phase == FSCD_LOAD |=> working_option_reg_o == $past(stored_option_byte_i))
    else $error("option byte not copied at reset");

  debug_gate_a: assert property ( // RULE5
    ce_i && dbg_en_req_i && sec_now |=> !dbg_en_o)
    else $error("debug module enabled while secure");

  no_permit_hold_a: assert property ( // RULE6
    ce_i && s.phase == FSCD_RUN && !permit && !blank_ok_i |=> s.opt == $past(s.opt))
    else $error("security changed without unlock permit");

  // secure_o trails the option register by one enabled edge
  key_unlock_a: assert property ( // RULE9
    key_close_ok_s |=> ((s.opt[1:0] == FSCD_SEC_OPEN) and (ce_i |=> !secure_o)))
    else $error("matching key did not unlock");

  key_miss_hold_a: assert property ( // RULE21
    ce_i && s.phase == FSCD_RUN && key_close && !s.key_ok && !blank_ok_i |=> s.opt == $past(s.opt))
    else $error("mismatching key changed security");

  prot_app_write_a: assert property ( // RULE12
    ce_i && s.phase == FSCD_RUN && apb_wr && reg_sel == FSCD_PROT_OFS && !bdm_src_i
    |=> working_protection_reg_o == $past(s.prot))
    else $error("application write changed protection");

  blank_unlock_a: assert property ( // RULE13
    blank_pass_s |=> !sec_now)
    else $error("blank check did not unlock");

  ratio_once_a: assert property ( // RULE14
    ce_i && loaded |=> s.ratio == $past(s.ratio))
    else $error("ratio register written twice");

  ratio_flag_a: assert property ( // RULE15
    ce_i && s.phase == FSCD_RUN && apb_wr && reg_sel == FSCD_RATIO_OFS |=> pe_enable_o)
    else $error("ratio-loaded flag not set by write");

  early_write_err_a: assert property ( // RULE20
    ce_i && s.phase == FSCD_RUN && early_wr && !key_hit && !blocked
    |=> access_error_flag_o && !mem_fwd_o.valid)
    else $error("early flash write not rejected");

  sequence div_wrap_s;
    ce_i && s.phase == FSCD_RUN && loaded && div_in_tick && s.dcnt == s.ratio[FSCD_RATIO_DIV_HI:0];
  endsequence

  open_code_a: assert property ( // RULE3
    ce_i && s.opt[1:0] == FSCD_SEC_OPEN |=> !secure_o)
    else $error("open security field did not read unsecured");

  reg_reach_a: assert property ( // RULE2
    ce_i && apb_setup && sec_now |=> pready_o)
    else $error("register not reachable while secure");

  key_write_eaten_a: assert property ( // RULE7
    ce_i && s.phase == FSCD_RUN && key_hit |=> !mem_fwd_o.valid)
    else $error("key write was forwarded");

  key_src_spoil_a: assert property ( // RULE10
    ce_i && s.phase == FSCD_RUN && key_hit && !key_src_ok |=> !s.key_ok)
    else $error("foreign key write did not spoil entry");

  presc_hold_a: assert property ( // RULE16
    ce_i && s.phase == FSCD_RUN && loaded && s.ratio[FSCD_RATIO_PS_BIT] && s.pcnt != FSCD_PRESC_LAST
    |=> s.dcnt == $past(s.dcnt) && !fclk_tick_o)
    else $error("divider stepped between prescaler ticks");

  div_wrap_tick_a: assert property ( // RULE17 RULE18
    div_wrap_s |=> fclk_tick_o && s.dcnt == 6'h00)
    else $error("divider did not tick at ratio end");

  unloaded_no_pe_a: assert property ( // RULE15
    ce_i && !loaded && !(apb_wr && reg_sel == FSCD_RATIO_OFS) |=> !pe_enable_o)
    else $error("program enabled before ratio write");

endmodule

// ===== test_flash_security_and_clock_divider.sv
`timescale 1ns/1ps
module test_flash_security_and_clock_divider;
  import fscd_pkg::*;

  localparam logic [63:0] KEY = 64'h8877665544332211;

  logic        core_clk_i;
  logic        arst_n_i;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        bdm_src;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  opt_byte;
  fscd_mreq_t  mem_req;
  fscd_mfwd_t  mem_fwd;
  logic        mem_rvalid;
  logic [7:0]  mem_rdata;
  fscd_mresp_t mem_resp;
  logic        blank_ok;
  logic        dbg_req;
  logic        dbg_en;
  logic        secure;
  logic [7:0]  opt_reg;
  logic [7:0]  prot_reg;
  logic        pe_en;
  logic        acc_err;
  logic        fclk_tick;
  int          err_count;
  int          total_checks;
  int          fwd_cnt = 0;
  logic [31:0] q;
  logic [7:0]  rb;
  logic        e;

  fscd_top dut (
    .core_clk_i               (core_clk_i),
    .arst_n_i                 (arst_n_i),
    .ce_i                     (1'b1),
    .psel_i                   (psel),
    .penable_i                (penable),
    .pwrite_i                 (pwrite),
    .paddr_i                  (paddr),
    .pwdata_i                 (pwdata),
    .bdm_src_i                (bdm_src),
    .prdata_o                 (prdata),
    .pready_o                 (pready),
    .pslverr_o                (pslverr),
    .stored_option_byte_i     (opt_byte),
    .stored_protection_byte_i (8'hf8),
    .stored_unlock_code_i     (KEY),
    .mem_req_i                (mem_req),
    .mem_fwd_o                (mem_fwd),
    .mem_rvalid_i             (mem_rvalid),
    .mem_rdata_i              (mem_rdata),
    .mem_resp_o               (mem_resp),
    .blank_ok_i               (blank_ok),
    .dbg_en_req_i             (dbg_req),
    .dbg_en_o                 (dbg_en),
    .secure_o                 (secure),
    .working_option_reg_o     (opt_reg),
    .working_protection_reg_o (prot_reg),
    .pe_enable_o              (pe_en),
    .access_error_flag_o      (acc_err),
    .fclk_tick_o              (fclk_tick)
  );

  initial
  begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  // memory answers reads exactly one cycle after a forward; counts forwards
  always @(posedge core_clk_i)
  begin
    mem_rvalid <= mem_fwd.valid & ~mem_fwd.write;
    mem_rdata  <= 8'h5a;
    if (mem_fwd.valid === 1'b1)
      fwd_cnt <= fwd_cnt + 1;
  end

  task check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task test_done;
    if (err_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // one apb transfer; request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    // no cycle count assumed; only the watchdog ends a stuck wait
    do
    begin
      @(posedge core_clk_i);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk_i);
  endtask

  // one-cycle memory request; reads wait for the answer, gap keeps writes apart
  task mem(input logic w, input logic s, input logic b, input logic t, input logic [15:0] a, input logic [7:0] d);
    int n;
    mem_req <= '{valid: 1'b1, write: w, src_secure: s, bdm: b, tgt_secure: t, tgt_flash: t, addr: a, wdata: d};
    @(posedge core_clk_i);
    mem_req.valid <= 1'b0;
    n = 0;
    rb = 8'hee;
    do
    begin
      @(posedge core_clk_i);
      n++;
      if (mem_resp.valid === 1'b1)
        rb = mem_resp.data;
    end
    while (n < 4);
  endtask

  task rst(input logic [7:0] o);
    opt_byte <= o;
    arst_n_i <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    // load edge, then one more so secure_o has caught up with the option byte
    repeat (3) @(posedge core_clk_i);
  endtask

  // key entry: select, eight writes (ascending, never adjacent), deselect
  task unlock(input logic [63:0] k, input logic s, input logic b);
    apb(1'b1, FSCD_CFG_OFS, 32'h20);
    for (int i = 0; i < 8; i++)
      mem(1'b1, s, b, 1'b1, FSCD_KEY_BASE + 16'(i), k[8*i +: 8]);
    apb(1'b1, FSCD_CFG_OFS, 32'h00);
    repeat (3) @(posedge core_clk_i);
  endtask

  initial
  begin
    int n;
    err_count = 0;
    total_checks = 0;
    {psel, penable, pwrite, bdm_src, blank_ok, dbg_req} = '0;
    paddr = '0;
    pwdata = '0;
    mem_req = '0;
    opt_byte = 8'h83;
    arst_n_i = 1'b0;
    // every security code, loaded at reset
    for (int s = 0; s < 4; s++)
    begin
      rst({6'h20, 2'(s)});
      check(opt_reg, {6'h20, 2'(s)});
      check(secure, s != 2);
    end
    rst(8'h83);
    check(pe_en, 0);
    mem(1'b1, 1'b1, 1'b0, 1'b1, 16'h8000, 8'h12);
    check(fwd_cnt, 0);
    check(acc_err, 1);
    apb(1'b1, FSCD_STAT_OFS, 32'h1);
    check(acc_err, 0);
    // ratio: prescale on, divisor field 16, about 184 khz from 25 mhz; second write ignored
    apb(1'b1, FSCD_RATIO_OFS, 32'h50);
    apb(1'b0, FSCD_RATIO_OFS, 32'h0);
    check(q, 32'hd0);
    check(pe_en, 1);
    apb(1'b1, FSCD_RATIO_OFS, 32'h05);
    apb(1'b0, FSCD_RATIO_OFS, 32'h0);
    check(q, 32'hd0);
    n = 0;
    while (fclk_tick !== 1'b1 && n < 300)
    begin
      @(posedge core_clk_i);
      n++;
    end
    n = 0;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end
    while (fclk_tick !== 1'b1 && n < 300);
    check(n, 136);
    apb(1'b0, 8'h40, 32'h0);
    check({e, q}, {1'b1, 32'h0});
    apb(1'b1, FSCD_OPT_OFS, 32'h0);
    check(opt_reg, 8'h83);
    // blocked and allowed memory traffic while secure
    mem(1'b0, 1'b0, 1'b0, 1'b1, 16'h8000, 8'h0);
    check({fwd_cnt[7:0], rb}, 16'h0000);
    mem(1'b0, 1'b1, 1'b1, 1'b1, 16'h0100, 8'h0);
    check({fwd_cnt[7:0], rb}, 16'h0000);
    mem(1'b0, 1'b1, 1'b0, 1'b1, 16'h8000, 8'h0);
    check({fwd_cnt[7:0], rb}, 16'h015a);
    mem(1'b0, 1'b0, 1'b1, 1'b0, 16'h0040, 8'h0);
    check({fwd_cnt[7:0], rb}, 16'h025a);
    apb(1'b1, FSCD_PROT_OFS, 32'h0);
    check(prot_reg, 8'hf8);
    bdm_src <= 1'b1;
    apb(1'b1, FSCD_PROT_OFS, 32'h7e);
    bdm_src <= 1'b0;
    check(prot_reg, 8'h7e);
    dbg_req <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    check(dbg_en, 0);
    unlock(KEY ^ 64'h0100, 1'b1, 1'b0);
    check({fwd_cnt[7:0], secure}, 9'h005);
    unlock(KEY, 1'b0, 1'b1);
    check(secure, 1);
    unlock(KEY, 1'b1, 1'b0);
    check({opt_reg[1:0], secure, dbg_en}, 4'b1001);
    // permit bit clear: no backdoor; blank check still opens
    rst(8'h03);
    unlock(KEY, 1'b1, 1'b0);
    check(secure, 1);
    blank_ok <= 1'b1;
    @(posedge core_clk_i);
    blank_ok <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    check({opt_reg[1:0], secure}, 3'b100);
    test_done;
  end

  // watchdog well past the few hundred cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    err_count++;
    test_done;
  end
endmodule
